// [rtl/remote_rx_leader_and_buffer.sv]
// remote receiver: leader detection, 72-bit frame buffer and register port
`timescale 1ns/10ps
`include "rmt_rx_defines.svh"
module remote_rx_leader_and_buffer #(
    parameter int FRAME_W = `FRAME_BITS,
    parameter int unsigned SYS_HZ = `SYS_CLK_HZ
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // demodulated remote input, idle high
    input wire logic rmt_in,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // status
    output logic leader_seen,
    output logic frame_done
);
    logic tick;
    logic [FRAME_W-1:0] frame_bits;
    logic [31:0] limits_r;
    logic [31:0] limits_nxt;
    logic [31:0] ctrl2_r;
    logic [31:0] ctrl2_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    rmt_rx_pkg::rx_state_t state_r;
    rmt_rx_pkg::rx_state_t state_nxt;
    logic [9:0] low_cnt_r;
    logic [9:0] low_cnt_nxt;
    logic [9:0] cyc_cnt_r;
    logic [9:0] cyc_cnt_nxt;
    logic in_d_r;
    logic leader_r;
    logic leader_nxt;
    logic done_r;
    logic done_nxt;
    logic shift_en;
    logic shift_bit;
    logic clear_buf;
    logic [9:0] lcmax;
    logic [9:0] lcmin;
    logic [9:0] llmax;
    logic [9:0] llmin;
    logic [9:0] end_low;
    logic [9:0] avg_cyc_r;
    logic [9:0] avg_cyc_nxt;
    logic need_leader;
    logic leader_ok;
    logic fall;

    sample_tick_gen #(
        .SYS_HZ(SYS_HZ),
        .SAMP_HZ(`SAMPLE_HZ)
    ) u_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick)
    );

    frame_shift_buffer #(
        .WIDTH(FRAME_W)
    ) u_buf (
        .sys_clk(sys_clk),
        .rst(rst),
        .clear(clear_buf),
        .shift_en(shift_en),
        .bit_in(shift_bit),
        .bits(frame_bits)
    );

    assign lcmax = {limits_r[`LCMAX_POS +: 8], 2'b00};
    assign lcmin = {limits_r[`LCMIN_POS +: 8], 2'b00};
    assign llmax = {limits_r[`LLMAX_POS +: 8], 2'b00};
    assign llmin = {limits_r[`LLMIN_POS +: 8], 2'b00};
    assign end_low = {2'b00, ctrl2_r[`END_LOW_POS +: 8]};
    assign need_leader = ctrl2_r[`LEADER_REQ_POS];
    assign fall = in_d_r & ~rmt_in;

    // leader window check; zero max cycle means no leader is accepted, zero max low means only the cycle length is checked
    always_comb begin
        if (limits_r[`LCMAX_POS +: 8] == 8'h00) begin
            leader_ok = 1'b0;
        end else if (limits_r[`LLMAX_POS +: 8] == 8'h00) begin
            leader_ok = (cyc_cnt_r >= lcmin) && (cyc_cnt_r <= lcmax);
        end else begin
            leader_ok = (cyc_cnt_r >= lcmin) && (cyc_cnt_r <= lcmax) &&
                        (low_cnt_r >= llmin) && (low_cnt_r <= llmax);
        end
    end

    // receive state: cycles measured falling edge to falling edge
    always_comb begin
        state_nxt = state_r;
        low_cnt_nxt = low_cnt_r;
        cyc_cnt_nxt = cyc_cnt_r;
        leader_nxt = leader_r;
        done_nxt = 1'b0;
        avg_cyc_nxt = avg_cyc_r;
        shift_en = 1'b0;
        shift_bit = 1'b0;
        clear_buf = 1'b0;
        case (state_r)
            rmt_rx_pkg::ST_IDLE: begin
                if (fall) begin
                    state_nxt = rmt_rx_pkg::ST_LOW;
                    low_cnt_nxt = '0;
                    cyc_cnt_nxt = '0;
                    leader_nxt = 1'b0;
                    clear_buf = 1'b1;
                end
            end
            rmt_rx_pkg::ST_LOW: begin
                // saturate: a stuck-low line must not wrap into a short leader
                if (tick && cyc_cnt_r != 10'h3FF) begin
                    low_cnt_nxt = low_cnt_r + 10'd1;
                    cyc_cnt_nxt = cyc_cnt_r + 10'd1;
                end
                if (rmt_in) begin
                    state_nxt = rmt_rx_pkg::ST_HIGH;
                end
            end
            rmt_rx_pkg::ST_HIGH: begin
                if (tick && cyc_cnt_r != 10'h3FF) begin
                    cyc_cnt_nxt = cyc_cnt_r + 10'd1;
                end
                if (fall) begin
                    state_nxt = rmt_rx_pkg::ST_LOW;
                    low_cnt_nxt = '0;
                    cyc_cnt_nxt = '0;
                    if (!leader_r && leader_ok) begin
                        leader_nxt = 1'b1;
                        avg_cyc_nxt = '0;
                    end else if (leader_r || !need_leader || low_cnt_r < llmin) begin
                        if (leader_r || !need_leader) begin
                            shift_en = 1'b1;
                            // long cycle against short cycle decides the bit
                            shift_bit = (avg_cyc_r != '0) && (cyc_cnt_r > avg_cyc_r);
                            if (avg_cyc_r == '0 || !shift_bit) begin
                                avg_cyc_nxt = cyc_cnt_r + (cyc_cnt_r >> 1);
                            end
                        end
                    end
                end else if (ctrl2_r[`END_LOW_POS +: 8] != 8'hFF && cyc_cnt_r > end_low
                             && cyc_cnt_r > lcmax) begin
                    state_nxt = rmt_rx_pkg::ST_IDLE;
                    done_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = rmt_rx_pkg::ST_IDLE;
            end
        endcase
    end

    // register writes
    always_comb begin
        limits_nxt = limits_r;
        ctrl2_nxt = ctrl2_r;
        if (reg_wr && reg_addr == `OFS_LEADER_LIMITS) begin
            limits_nxt = reg_wdata;
        end
        if (reg_wr && reg_addr == `OFS_RX_CTRL_TWO) begin
            ctrl2_nxt = {6'h00, reg_wdata[`LEADER_REQ_POS], 9'h000, reg_wdata[15:0]};
        end
    end

    // reads only select data, no state changes
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `OFS_BUF_LOW: rdata_nxt = frame_bits[31:0];
                `OFS_BUF_MID: rdata_nxt = frame_bits[63:32];
                `OFS_BUF_TOP: rdata_nxt = {24'h00_0000, frame_bits[71:64]};
                `OFS_LEADER_LIMITS: rdata_nxt = limits_r;
                `OFS_RX_CTRL_TWO: rdata_nxt = ctrl2_r;
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= rmt_rx_pkg::ST_IDLE;
            low_cnt_r <= 10'h000;
            cyc_cnt_r <= 10'h000;
            avg_cyc_r <= 10'h000;
            in_d_r <= 1'b1;
            leader_r <= 1'b0;
            done_r <= 1'b0;
            limits_r <= `LIMITS_RESET;
            ctrl2_r <= `CTRL_TWO_RESET;
            rdata_r <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            low_cnt_r <= low_cnt_nxt;
            cyc_cnt_r <= cyc_cnt_nxt;
            avg_cyc_r <= avg_cyc_nxt;
            in_d_r <= rmt_in;
            leader_r <= leader_nxt;
            done_r <= done_nxt;
            limits_r <= limits_nxt;
            ctrl2_r <= ctrl2_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign leader_seen = leader_r;
    assign frame_done = done_r;
endmodule // remote_rx_leader_and_buffer

// [rtl/rmt_rx_defines.svh]
// register offsets, field positions, reset values and timing counts for the remote receiver
`ifndef RMT_RX_DEFINES_SVH
`define RMT_RX_DEFINES_SVH
`define OFS_BUF_LOW 8'h08
`define OFS_BUF_MID 8'h0C
`define OFS_BUF_TOP 8'h10
`define OFS_LEADER_LIMITS 8'h14
`define OFS_RX_CTRL_TWO 8'h18
`define LCMAX_POS 24
`define LCMIN_POS 16
`define LLMAX_POS 8
`define LLMIN_POS 0
`define LEADER_REQ_POS 25
`define LIMITS_RESET 32'h0000_0000
`define CTRL_TWO_RESET 32'h0000_FFFF
`define END_LOW_POS 8
`define SYS_CLK_HZ 20000000
`define SAMPLE_HZ 32768
`define UNIT_SAMPLES 4
`define FRAME_BITS 72
`endif

// [rtl/rmt_rx_pkg.sv]
// types shared by the remote receiver files
package rmt_rx_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOW,
        ST_HIGH
    } rx_state_t;
endpackage

// [rtl/sample_tick_gen.sv]
// sampling clock tick from the system clock by fractional accumulation
`timescale 1ns/10ps
`include "rmt_rx_defines.svh"
module sample_tick_gen #(
    parameter int unsigned SYS_HZ = `SYS_CLK_HZ,
    parameter int unsigned SAMP_HZ = `SAMPLE_HZ
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // tick out
    output logic tick
);
    logic [31:0] acc_r;
    logic [31:0] acc_nxt;
    logic tick_r;
    logic tick_nxt;

    // accumulator keeps the long-run rate exact, jitter is one clock
    always_comb begin
        if (acc_r + SAMP_HZ >= SYS_HZ) begin
            acc_nxt = acc_r + SAMP_HZ - SYS_HZ;
            tick_nxt = 1'b1;
        end else begin
            acc_nxt = acc_r + SAMP_HZ;
            tick_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acc_r <= 32'h0000_0000;
            tick_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule // sample_tick_gen

// [rtl/frame_shift_buffer.sv]
// frame bit store: shifts in msb first, newest bit at position 0
`timescale 1ns/10ps
`include "rmt_rx_defines.svh"
module frame_shift_buffer #(
    parameter int WIDTH = `FRAME_BITS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // control
    input wire logic clear,
    input wire logic shift_en,
    input wire logic bit_in,
    // stored frame
    output logic [WIDTH-1:0] bits
);
    logic [WIDTH-1:0] bits_r;
    logic [WIDTH-1:0] bits_nxt;

    always_comb begin
        bits_nxt = bits_r;
        if (clear) begin
            bits_nxt = '0;
        end
        if (shift_en) begin
            bits_nxt = {bits_nxt[WIDTH-2:0], bit_in};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bits_r <= '0;
        end else begin
            bits_r <= bits_nxt;
        end
    end

    assign bits = bits_r;
endmodule // frame_shift_buffer

// [testbench/rx_port_checker.sv]
// port assertions for the remote receiver register side
`timescale 1ns/10ps
module rx_port_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // watched ports
    input wire logic rmt_in,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic wr14, rd14, wr18, rd18, wr0c, rd0c, unmapped;
    assign wr14 = reg_wr && reg_addr == 8'h14;
    assign rd14 = reg_rd && reg_addr == 8'h14;
    assign wr18 = reg_wr && reg_addr == 8'h18;
    assign rd18 = reg_rd && reg_addr == 8'h18;
    assign wr0c = reg_wr && reg_addr == 8'h0C && rmt_in;
    assign rd0c = reg_rd && reg_addr == 8'h0C && rmt_in;
    assign unmapped = !(reg_addr inside {8'h08, 8'h0C, 8'h10, 8'h14, 8'h18});
    unmapped_zero_a: assert property (reg_rd && unmapped |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    top_byte_a: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata[31:8] == 24'h00_0000)
        else $error("top byte upper bits set");
    cycle_max_a: assert property (wr14 ##1 rd14 |=> reg_rdata[31:24] == $past(reg_wdata[31:24], 2))
        else $error("max cycle field lost");
    cycle_min_a: assert property (wr14 ##1 rd14 |=> reg_rdata[23:16] == $past(reg_wdata[23:16], 2))
        else $error("min cycle field lost");
    low_max_a: assert property (wr14 ##1 rd14 |=> reg_rdata[15:8] == $past(reg_wdata[15:8], 2))
        else $error("max low field lost");
    low_min_a: assert property (wr14 ##1 rd14 |=> reg_rdata[7:0] == $past(reg_wdata[7:0], 2))
        else $error("min low field lost");
    leader_bit_a: assert property (wr18 ##1 rd18 |=> reg_rdata[25] == $past(reg_wdata[25], 2))
        else $error("leader bit lost");
    buf_ro_a: assert property (rd0c ##1 wr0c ##1 rd0c |=> reg_rdata == $past(reg_rdata, 2))
        else $error("buffer took a write");
    reread_same_a: assert property (rd0c ##1 rd0c |=> reg_rdata == $past(reg_rdata))
        else $error("buffer read changed it");
endmodule // rx_port_checker

bind remote_rx_leader_and_buffer rx_port_checker chk_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .rmt_in(rmt_in),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
);

// [testbench/remote_tx_model.sv]
// remote transmitter model driving the demodulated line, idle high
`timescale 1ns/10ps
module remote_tx_model #(
    parameter int CPT = 2
) (
    // clock
    input wire logic sys_clk,
    // line out
    output logic rmt_in
);
    initial rmt_in = 1'b1;
    task automatic level(input logic v, input int ticks);
        @(posedge sys_clk);
        rmt_in <= v;
        repeat (ticks * CPT - 1) @(posedge sys_clk);
    endtask
    // optional leader, then one cycle per bit, earliest first, closing fall
    task automatic frame(input logic [71:0] d, input int n, input int lo, input int hi);
        if (lo > 0) begin
            level(1'b0, lo);
            level(1'b1, hi);
        end
        for (int i = n - 1; i >= 0; i--) begin
            level(1'b0, 4);
            level(1'b1, d[i] ? 12 : 4);
        end
        level(1'b0, 4);
        @(posedge sys_clk);
        rmt_in <= 1'b1;
    endtask
endmodule // remote_tx_model

// [testbench/tb.sv]
// self-checking bench for the remote receiver
`timescale 1ns/10ps
module tb;
    localparam int unsigned HZ = 65536;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic rmt_in;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic leader_seen;
    logic frame_done;
    int errors = 0;
    int checks = 0;
    logic [71:0] d;
    logic [31:0] v;
    int lo[4] = '{40, 20, 40, 48};
    int hi[4] = '{20, 40, 90, 4};
    logic ok[4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    remote_rx_leader_and_buffer #(.FRAME_W(72), .SYS_HZ(HZ)) dut (.sys_clk(sys_clk), .rst(rst),
        .rmt_in(rmt_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .leader_seen(leader_seen),
        .frame_done(frame_done));
    remote_tx_model #(.CPT(HZ / 32768)) rc (.sys_clk(sys_clk), .rmt_in(rmt_in));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    // end limit 0xA0 ticks, far above any bit cycle
    function automatic logic [31:0] ctrl_two(input logic lreq);
        return {6'h00, lreq, 9'h000, 8'hA0, 8'hFF};
    endfunction
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] x);
        @(posedge sys_clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= x;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        bus(1'b0, 1'b1, a, 32'h0000_0000);
        bus(1'b0, 1'b0, a, 32'h0000_0000);
        @(negedge sys_clk);
        chk(name, exp, reg_rdata);
    endtask
    task automatic conclude();
        if (errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge sys_clk);
        errors++;
        conclude();
    end
    initial begin
        void'($urandom(97));
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h0C, 32'h0000_0000, "mid_word");
        rd(8'h10, 32'h0000_0000, "top_byte");
        rd(8'h14, 32'h0000_0000, "limits");
        rd(8'h2C, 32'h0000_0000, "unmapped");
        for (int i = 0; i < 4; i++) begin
            v = $urandom();
            bus(1'b1, 1'b0, 8'h14, v);
            rd(8'h14, v, "limits");
        end
        bus(1'b1, 1'b0, 8'h14, 32'h0000_0000);
        bus(1'b1, 1'b0, 8'h18, ctrl_two(1'b0));
        rd(8'h18, ctrl_two(1'b0), "ctrl_two");
        // long frame then short one: the short one must clear the old bits
        for (int k = 0; k < 2; k++) begin
            d = {8'($urandom()), $urandom(), $urandom()};
            d = d >> (k * 52);
            d[71 - k * 52] = 1'b0;
            rc.frame(d, 72 - k * 52, 0, 0);
            for (int n = 0; n < 400 && frame_done !== 1'b1; n++) @(negedge sys_clk);
            chk("frame_done", 32'h0000_0001, {31'h0, frame_done});
            rd(8'h08, d[31:0], "low_word");
            rd(8'h0C, d[63:32], "mid_word");
            rd(8'h10, {24'h00_0000, d[71:64]}, "top_byte");
            bus(1'b0, 1'b1, 8'h0C, 32'h0000_0000);
            bus(1'b1, 1'b0, 8'h0C, ~d[63:32]);
            bus(1'b0, 1'b1, 8'h0C, 32'h0000_0000);
            rd(8'h0C, d[63:32], "mid_word");
        end
        // leader window: one accepted leader, then too short low, too long cycle and too long low rejected
        bus(1'b1, 1'b0, 8'h14, 32'h140C_0B08);
        bus(1'b1, 1'b0, 8'h18, ctrl_two(1'b1));
        bus(1'b0, 1'b0, 8'h18, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            d = {8'($urandom()), $urandom(), $urandom()} & 72'h7F;
            fork
                rc.frame(d, 8, lo[i], hi[i]);
                begin
                    repeat ((lo[i] + hi[i]) * 2 + 40) @(posedge sys_clk);
                    @(negedge sys_clk);
                    chk("leader_seen", {31'h0, ok[i]}, {31'h0, leader_seen});
                end
            join
            repeat (400) @(posedge sys_clk);
        end
        conclude();
    end
endmodule // tb
